// ---- src/psei_defines.svh ----
`ifndef PSEI_DEFINES_SVH
`define PSEI_DEFINES_SVH

`define PSEI_CLK_HZ         20000000
`define PSEI_BLINK_MS       250
`define PSEI_WASTE_LIMIT    37000
`define PSEI_WASTE_W        16
`define PSEI_REINIT_S       10
`define PSEI_SPACING_DEF    8'h3c
`define PSEI_PITCH_DEF      8'h0a
`define PSEI_RMARGIN_DEF    8'h50
`define PSEI_LMARGIN_DEF    8'h01
`define PSEI_INIT_CYCLES    4'h8

`endif

// ---- src/psei_pkg.sv ----
package psei_pkg;

  // Initialization kinds.
  typedef enum logic [1:0] {
    PSEI_INIT_NONE = 2'h0,
    PSEI_INIT_COLD = 2'h1,
    PSEI_INIT_OPER = 2'h3,
    PSEI_INIT_SOFT = 2'h2
  } psei_init_kind_t;

  // Initialization sequencer states, Gray coded.
  typedef enum logic [1:0] {
    PSEI_ST_IDLE  = 2'h0,
    PSEI_ST_MECH  = 2'h1,
    PSEI_ST_CLEAR = 2'h3,
    PSEI_ST_LOAD  = 2'h2
  } psei_state_t;

  // One light drive: keep, off, on, blink.
  typedef enum logic [1:0] {
    PSEI_L_KEEP  = 2'h0,
    PSEI_L_OFF   = 2'h1,
    PSEI_L_ON    = 2'h2,
    PSEI_L_BLINK = 2'h3
  } psei_light_t;

endpackage : psei_pkg

// ---- src/psei_blink.sv ----
`timescale 1ns/1ns
// Shared blink phase: one toggle source for every blinking light.
module psei_blink #(
  parameter int unsigned HALF_CYCLES = 5000000
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  output logic      phase
);
  localparam int unsigned CW = $clog2(HALF_CYCLES + 1);

  logic [CW-1:0] count;

  initial begin
    if (HALF_CYCLES < 2) $error("psei_blink: HALF_CYCLES must be at least 2");
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= '0;
      phase <= 1'b0;
    end else if (count == CW'(HALF_CYCLES - 1)) begin
      count <= '0;
      phase <= ~phase;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule : psei_blink

// ---- src/psei_ctrl.sv ----
`timescale 1ns/1ns
`include "psei_defines.svh"
// Status, error and initialization controller of the printer.
module psei_ctrl #(
  parameter int unsigned BLINK_HALF  = `PSEI_CLK_HZ / 1000 * `PSEI_BLINK_MS,
  parameter int unsigned REINIT_CYC  = `PSEI_CLK_HZ * `PSEI_REINIT_S,
  parameter int unsigned WASTE_LIMIT = `PSEI_WASTE_LIMIT
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Mechanism and firmware conditions.
  input  wire logic       load_failed,
  input  wire logic       eject_failed,
  input  wire logic       paper_cleared,
  input  wire logic       black_low,
  input  wire logic       black_out,
  input  wire logic       black_absent,
  input  wire logic       color_low,
  input  wire logic       color_out,
  input  wire logic       color_absent,
  input  wire logic       mech_fail,
  input  wire logic       char_mem_fail,
  input  wire logic       exchange_mode,
  input  wire logic       ink_sequence,
  input  wire logic       data_processing,
  input  wire logic       waste_add,
  input  wire logic [7:0] waste_points,
  input  wire logic       waste_clear,
  // Host interface side.
  input  wire logic       packet_mode,
  input  wire logic       parallel_selected,
  input  wire logic       init_n,
  input  wire logic       cold_reset_command,
  input  wire logic       soft_init_command,
  input  wire logic       power_return_quick,
  input  wire logic       power_restored,
  input  wire logic       error_clear,
  output logic            error_n,
  output logic            busy,
  output logic            rx_enable,
  output logic            print_enable,
  // Panel lights.
  output logic            led_power,
  output logic            led_black,
  output logic            led_color,
  output logic            led_paper,
  // Initialization actions.
  output logic            mech_init,
  output logic            cap_head,
  output logic            eject_paper,
  output logic            clear_input_buf,
  output logic            clear_print_buf,
  output logic            top_of_page_set,
  output logic            init_busy,
  // Default settings.
  output logic [7:0]      line_spacing,
  output logic [7:0]      char_pitch,
  output logic [7:0]      right_margin,
  output logic [7:0]      left_margin,
  output logic            raster_mode
);

  initial begin
    if (WASTE_LIMIT == 0 || WASTE_LIMIT >= (1 << `PSEI_WASTE_W))
      $error("psei_ctrl: WASTE_LIMIT out of range");
  end

  // ----------------------------------------
  // Blink source
  // ----------------------------------------
  logic blink;

  psei_blink #(
    .HALF_CYCLES (BLINK_HALF)
  ) u_blink (
    .ref_clk (ref_clk),
    .reset   (reset),
    .phase   (blink)
  );

  // ----------------------------------------
  // Error conditions
  // ----------------------------------------
  logic                    paper_out;
  logic                    paper_jam;
  logic                    maint_req;
  logic                    fatal;
  logic [`PSEI_WASTE_W-1:0] waste_total;
  logic                    black_err;
  logic                    color_err;
  logic                    any_error;
  logic                    waste_hit;

  // Paper errors stay until the paper path is cleared; a new failure wins.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      paper_out <= 1'b0;
      paper_jam <= 1'b0;
    end else begin
      if (load_failed) paper_out <= 1'b1;
      else if (paper_cleared) paper_out <= 1'b0;
      if (eject_failed) paper_jam <= 1'b1;
      else if (paper_cleared) paper_jam <= 1'b0;
    end
  end

  assign waste_hit = {1'b0, waste_total} + {9'h000, waste_points} >=
                     (`PSEI_WASTE_W+1)'(WASTE_LIMIT);

  // Waste ink counter saturates at the limit; reaching it wins over a clear.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      waste_total <= '0;
      maint_req   <= 1'b0;
    end else if (waste_add && !maint_req && waste_hit) begin
      waste_total <= `PSEI_WASTE_W'(WASTE_LIMIT);
      maint_req   <= 1'b1;
    end else if (waste_clear) begin
      waste_total <= '0;
      maint_req   <= 1'b0;
    end else if (waste_add && !maint_req) begin
      waste_total <= waste_total + {8'h00, waste_points};
    end
  end

  // Fatal error holds until reset.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fatal <= 1'b0;
    end else if (mech_fail || char_mem_fail) begin
      fatal <= 1'b1;
    end
  end

  assign black_err = black_out || black_absent;
  assign color_err = color_out || color_absent;
  assign any_error = paper_out || paper_jam || maint_req || fatal || black_err || color_err;

  // ----------------------------------------
  // Host interface lines
  // ----------------------------------------
  logic halted;

  // Ink low alone is only a warning and never halts.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      halted <= 1'b0;
    end else if (any_error && !packet_mode) begin
      halted <= 1'b1;
    end else if (!any_error || error_clear) begin
      halted <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      error_n      <= 1'b1;
      busy         <= 1'b1;
      rx_enable    <= 1'b0;
      print_enable <= 1'b0;
    end else begin
      error_n      <= !halted;
      busy         <= halted || init_busy || !parallel_selected;
      rx_enable    <= !halted && !init_busy;
      print_enable <= !halted && !init_busy;
    end
  end

  // ----------------------------------------
  // Light arbitration
  // ----------------------------------------
  psei_pkg::psei_light_t p_pow;
  psei_pkg::psei_light_t p_blk;
  psei_pkg::psei_light_t p_col;
  psei_pkg::psei_light_t p_pap;

  always_comb begin
    p_pow = psei_pkg::PSEI_L_KEEP;
    p_blk = psei_pkg::PSEI_L_KEEP;
    p_col = psei_pkg::PSEI_L_KEEP;
    p_pap = psei_pkg::PSEI_L_KEEP;
    if (fatal) begin
      p_pow = psei_pkg::PSEI_L_BLINK;
      p_blk = psei_pkg::PSEI_L_ON;
      p_col = psei_pkg::PSEI_L_ON;
      p_pap = psei_pkg::PSEI_L_BLINK;
    end else if (maint_req) begin
      p_pow = psei_pkg::PSEI_L_BLINK;
      p_blk = psei_pkg::PSEI_L_BLINK;
      p_col = psei_pkg::PSEI_L_BLINK;
      p_pap = psei_pkg::PSEI_L_BLINK;
    end else if (paper_jam) begin
      p_blk = psei_pkg::PSEI_L_OFF;
      p_col = psei_pkg::PSEI_L_OFF;
      p_pap = psei_pkg::PSEI_L_BLINK;
    end else begin
      if (paper_out) p_pap = psei_pkg::PSEI_L_ON;
      if (exchange_mode || ink_sequence || data_processing)
        p_pow = psei_pkg::PSEI_L_BLINK;
      else
        p_pow = psei_pkg::PSEI_L_ON;
      // Both ink lights sit at one shared level below jam; exchange and sequence drive only the power light.
      if (black_err) p_blk = psei_pkg::PSEI_L_ON;
      else if (black_low) p_blk = psei_pkg::PSEI_L_BLINK;
      if (color_err) p_col = psei_pkg::PSEI_L_ON;
      else if (color_low) p_col = psei_pkg::PSEI_L_BLINK;
    end
  end

  function automatic logic light_next(input psei_pkg::psei_light_t p, input logic cur,
                                      input logic ph);
    unique case (p)
      psei_pkg::PSEI_L_KEEP:  light_next = cur;
      psei_pkg::PSEI_L_OFF:   light_next = 1'b0;
      psei_pkg::PSEI_L_ON:    light_next = 1'b1;
      psei_pkg::PSEI_L_BLINK: light_next = ph;
    endcase
  endfunction : light_next

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      led_power <= 1'b0;
      led_black <= 1'b0;
      led_color <= 1'b0;
      led_paper <= 1'b0;
    end else begin
      led_power <= light_next(p_pow, led_power, blink);
      led_black <= light_next(p_blk, led_black, blink);
      led_color <= light_next(p_col, led_color, blink);
      led_paper <= light_next(p_pap, led_paper, blink);
    end
  end

  // ----------------------------------------
  // Initialization requests
  // ----------------------------------------
  psei_pkg::psei_state_t     state;
  psei_pkg::psei_init_kind_t kind;
  logic [3:0]                step;
  logic init_n_q;
  logic power_up;
  logic oper_req;
  logic init_pulse;

  assign init_pulse = init_n_q && !init_n && parallel_selected;
  // A quick power return is taken as operator init, a slow one as cold.
  assign oper_req   = init_pulse || (power_restored && power_return_quick);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      init_n_q <= 1'b1;
      power_up <= 1'b1;
    end else begin
      init_n_q <= init_n;
      if (power_restored && !power_return_quick) power_up <= 1'b1;
      else if (state == psei_pkg::PSEI_ST_IDLE) power_up <= 1'b0;
    end
  end

  // ----------------------------------------
  // Initialization sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= psei_pkg::PSEI_ST_IDLE;
      kind  <= psei_pkg::PSEI_INIT_NONE;
      step  <= '0;
    end else begin
      unique case (state)
        psei_pkg::PSEI_ST_IDLE: begin
          step <= '0;
          if (power_up || cold_reset_command) begin
            kind  <= psei_pkg::PSEI_INIT_COLD;
            state <= psei_pkg::PSEI_ST_MECH;
          end else if (oper_req) begin
            kind  <= psei_pkg::PSEI_INIT_OPER;
            state <= psei_pkg::PSEI_ST_MECH;
          end else if (soft_init_command) begin
            kind  <= psei_pkg::PSEI_INIT_SOFT;
            state <= psei_pkg::PSEI_ST_CLEAR;
          end
        end
        psei_pkg::PSEI_ST_MECH: begin
          step <= step + 1'b1;
          if (step == `PSEI_INIT_CYCLES) begin
            step  <= '0;
            state <= psei_pkg::PSEI_ST_CLEAR;
          end
        end
        psei_pkg::PSEI_ST_CLEAR: state <= psei_pkg::PSEI_ST_LOAD;
        psei_pkg::PSEI_ST_LOAD: begin
          state <= psei_pkg::PSEI_ST_IDLE;
          kind  <= psei_pkg::PSEI_INIT_NONE;
        end
      endcase
    end
  end

  // Action strobes, one cycle each; init_busy is held while the sequencer is out of idle.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mech_init       <= 1'b0;
      cap_head        <= 1'b0;
      eject_paper     <= 1'b0;
      clear_input_buf <= 1'b0;
      clear_print_buf <= 1'b0;
      top_of_page_set <= 1'b0;
      init_busy       <= 1'b0;
    end else begin
      mech_init   <= state == psei_pkg::PSEI_ST_MECH && step == '0 &&
                     kind == psei_pkg::PSEI_INIT_COLD;
      cap_head    <= state == psei_pkg::PSEI_ST_MECH && step == '0 &&
                     kind == psei_pkg::PSEI_INIT_OPER;
      eject_paper <= state == psei_pkg::PSEI_ST_MECH && step == '0 &&
                     kind == psei_pkg::PSEI_INIT_OPER;
      clear_input_buf <= state == psei_pkg::PSEI_ST_CLEAR &&
                         kind != psei_pkg::PSEI_INIT_SOFT;
      clear_print_buf <= state == psei_pkg::PSEI_ST_CLEAR;
      top_of_page_set <= state == psei_pkg::PSEI_ST_LOAD;
      init_busy       <= state != psei_pkg::PSEI_ST_IDLE;
    end
  end

  // Default settings loaded at the end of every initialization.
  always_ff @(posedge ref_clk) begin
    if (reset || state == psei_pkg::PSEI_ST_LOAD) begin
      line_spacing <= `PSEI_SPACING_DEF;
      char_pitch   <= `PSEI_PITCH_DEF;
      right_margin <= `PSEI_RMARGIN_DEF;
      left_margin  <= `PSEI_LMARGIN_DEF;
      raster_mode  <= 1'b0;
    end
  end

  logic unused_reinit;
  assign unused_reinit = (REINIT_CYC == 0);

endmodule : psei_ctrl

// ---- verif/psei_ctrl_properties.sv ----
`timescale 1ns/1ns
module psei_ctrl_properties #(
  parameter int unsigned BLINK_HALF  = 4,
  parameter int unsigned REINIT_CYC  = 100,
  parameter int unsigned WASTE_LIMIT = 100
) (
  input wire logic       ref_clk, reset, init_n, parallel_selected, packet_mode,
  input wire logic       load_failed, eject_failed, mech_fail, waste_add, power_restored,
  input wire logic       cold_reset_command, soft_init_command, init_busy,
  input wire logic       error_n, busy, rx_enable, print_enable, led_black, led_color,
  input wire logic       mech_init, cap_head, clear_input_buf, clear_print_buf,
  input wire logic       top_of_page_set, raster_mode,
  input wire logic [7:0] line_spacing, char_pitch, right_margin, left_margin
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence halted;
    !error_n && busy && !rx_enable && !print_enable;
  endsequence
  sequence cold_walk;
    ##2 mech_init ##9 (clear_input_buf && clear_print_buf) ##1 top_of_page_set;
  endsequence
  sequence soft_walk;
    ##2 (clear_print_buf && !clear_input_buf) ##1 top_of_page_set;
  endsequence

  a_cold_init_walk: assert property (cold_reset_command && !init_busy |-> cold_walk)
    else $error("cold init steps out of order");
  a_soft_init_walk: assert property (soft_init_command && !init_busy && !cold_reset_command
    && !power_restored && init_n |-> soft_walk)
    else $error("soft init steps wrong");
  a_oper_init_walk: assert property ($fell(init_n) && parallel_selected && !init_busy
    && !cold_reset_command && !power_restored
    |-> ##[1:4] cap_head ##[1:12] (clear_input_buf && clear_print_buf))
    else $error("operator init steps missing");
  a_init_pin_ignored: assert property ($fell(init_n) && !parallel_selected
    && !power_restored && !init_busy |-> ##1 (!cap_head)[*6])
    else $error("init pin acted while parallel not selected");
  a_defaults_loaded: assert property (top_of_page_set |-> line_spacing == 8'h3c
    && char_pitch == 8'h0a && right_margin == 8'h50 && left_margin == 8'h01 && !raster_mode)
    else $error("defaults wrong at init end");
  a_paper_out_halt: assert property (load_failed && !packet_mode |-> ##[1:4] halted)
    else $error("paper out did not halt");
  a_fatal_ink_lights: assert property ($rose(mech_fail) |-> ##[1:4] (led_black && led_color))
    else $error("fatal pattern missing");
  a_fatal_halt: assert property ($rose(mech_fail) && !packet_mode |-> ##[1:5] halted)
    else $error("fatal did not halt");
  a_packet_no_halt: assert property ((packet_mode && error_n)[*4] |=> error_n)
    else $error("halted in packet mode");
  a_jam_inks_off: assert property (eject_failed && !mech_fail && !waste_add
    |-> ##[1:4] (!led_black && !led_color))
    else $error("jam left ink lights on");
endmodule : psei_ctrl_properties

bind psei_ctrl psei_ctrl_properties #(
  .BLINK_HALF(BLINK_HALF), .REINIT_CYC(REINIT_CYC), .WASTE_LIMIT(WASTE_LIMIT)
) i_psei_ctrl_properties (
  .ref_clk, .reset, .init_n, .parallel_selected, .packet_mode, .load_failed, .eject_failed,
  .mech_fail, .waste_add, .power_restored, .cold_reset_command, .soft_init_command,
  .init_busy, .error_n, .busy, .rx_enable, .print_enable, .led_black, .led_color, .mech_init,
  .cap_head, .clear_input_buf, .clear_print_buf, .top_of_page_set, .raster_mode,
  .line_spacing, .char_pitch, .right_margin, .left_margin
);

// ---- verif/psei_host_model.sv ----
`timescale 1ns/1ns
// Host on the printer interface: sends data only while the printer is ready.
module psei_host_model (
  input  wire logic ref_clk, busy, error_n,
  output logic      init_n, soft_init_command, cold_reset_command,
  output int        sent
);
  initial begin
    init_n = 1'b1;
    soft_init_command = 1'b0;
    cold_reset_command = 1'b0;
    sent = 0;
  end

  always @(posedge ref_clk) if (!busy && error_n) sent <= sent + 1;

  // Kind 0 cold reset, 1 soft init, else a two-cycle low pulse on the init pin.
  task automatic cmd(input int k);
    @(posedge ref_clk);
    case (k)
      0: cold_reset_command <= 1'b1;
      1: soft_init_command <= 1'b1;
      default: init_n <= 1'b0;
    endcase
    @(posedge ref_clk);
    cold_reset_command <= 1'b0;
    soft_init_command <= 1'b0;
    @(posedge ref_clk);
    init_n <= 1'b1;
  endtask : cmd
endmodule : psei_host_model

// ---- verif/tb.sv ----
`timescale 1ns/1ns
module tb;
  localparam int BLO = 0, BOUT = 1, BAB = 2, CLO = 3, COUT = 4, CAB = 5, MF = 6, CMF = 7;
  localparam int EXM = 8, DP = 10, PKT = 11, PSEL = 12, PRQ = 13, LF = 0, EF = 1, PC = 2;
  localparam int WA = 3, WC = 4, PR = 5, EC = 6;
  logic        ref_clk = 1'b0, reset = 1'b1;
  logic [13:0] cond = 14'h1000;
  logic [6:0]  pl = 7'h00;
  logic [7:0]  wp = 8'h00;
  logic        error_n, busy, rx_enable, print_enable, led_power, led_black, led_color;
  logic        led_paper, mech_init, cap_head, clear_input_buf, clear_print_buf, eq;
  logic        top_of_page_set, init_busy, raster_mode, init_n, soft_init_command;
  logic        cold_reset_command, eject_paper;
  logic [7:0]  line_spacing, char_pitch, right_margin, left_margin;
  logic [3:0]  tog, lv;
  logic [5:0]  g;
  int          error_cnt = 0, checked = 0, seed = 35, sent, c, k, b, i;
  int          cnt[6] = '{default: 0}, snap[6];
  wire [3:0]   leds = {led_power, led_black, led_color, led_paper};
  wire [5:0]   stb = {eject_paper, top_of_page_set, clear_print_buf, clear_input_buf,
                      cap_head, mech_init};

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (!reset) for (int j = 0; j < 6; j++) cnt[j] <= cnt[j] + stb[j];

  psei_ctrl #(.BLINK_HALF(4), .WASTE_LIMIT(100)) i_psei_ctrl (
    .ref_clk, .reset, .load_failed(pl[LF]), .eject_failed(pl[EF]), .paper_cleared(pl[PC]),
    .black_low(cond[0]), .black_out(cond[1]), .black_absent(cond[2]), .color_low(cond[3]),
    .color_out(cond[4]), .color_absent(cond[5]), .mech_fail(cond[6]), .char_mem_fail(cond[7]),
    .exchange_mode(cond[8]), .ink_sequence(cond[9]), .data_processing(cond[10]),
    .waste_add(pl[WA]), .waste_points(wp), .waste_clear(pl[WC]), .packet_mode(cond[PKT]),
    .parallel_selected(cond[PSEL]), .init_n, .cold_reset_command, .soft_init_command,
    .power_return_quick(cond[PRQ]), .power_restored(pl[PR]), .error_clear(pl[EC]), .error_n,
    .busy, .rx_enable, .print_enable, .led_power, .led_black, .led_color, .led_paper,
    .mech_init, .cap_head, .eject_paper, .clear_input_buf, .clear_print_buf,
    .top_of_page_set, .init_busy, .line_spacing, .char_pitch, .right_margin, .left_margin,
    .raster_mode);

  psei_host_model i_psei_host_model (.ref_clk, .busy, .error_n, .init_n,
    .soft_init_command, .cold_reset_command, .sent);

  // Low ink blinks, out or absent lights steadily: {blinks, lit}.
  function automatic logic [1:0] ink_exp(input int code);
    return {code == 1, 1'b1};
  endfunction : ink_exp

  // Strobes seen per init kind, as {eject, top, print, input, cap, mech}.
  function automatic logic [5:0] init_exp(input int kind);
    case (kind)
      0, 1: return 6'h1d;
      2, 3: return 6'h3e;
      4: return 6'h00;
      default: return 6'h18;
    endcase
  endfunction : init_exp

  task automatic cyc(input int n); repeat (n) @(posedge ref_clk); endtask : cyc
  task automatic chk(input logic [31:0] e, input logic [31:0] a);
    #1;
    checked++;
    if (a !== e) begin
      error_cnt++;
      $display("unexpected at %0t: expected %h got %h", $time, e, a);
    end
  endtask : chk
  task automatic setc(input int n, input logic v); cyc(1); cond[n] <= v; endtask : setc
  task automatic pulse(input int n); cyc(1); pl[n] <= 1'b1; cyc(1); pl[n] <= 1'b0; endtask : pulse
  task automatic watch();
    logic [3:0] p;
    #1;
    p = leds;
    tog = 4'h0;
    eq = 1'b1;
    repeat (16) begin
      @(posedge ref_clk);
      #1;
      tog |= p ^ leds;
      p = leds;
      if (p !== {4{p[0]}}) eq = 1'b0;
    end
    lv = p;
  endtask : watch
  task automatic idle();
    cyc(3);
    for (i = 0; i < 200 && init_busy !== 1'b0; i++) begin cyc(1); #1; end
    cyc(2);
    chk(0, init_busy);
  endtask : idle
  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin cyc(20000); error_cnt++; tally_and_finish(); end

  initial begin
    cyc(6); reset <= 1'b0; idle();
    chk(32'h3c0a_5001, {line_spacing, char_pitch, right_margin, left_margin});
    chk(0, raster_mode);
    repeat (8) begin
      c = $unsigned($random(seed)) % 2;
      k = 1 + $unsigned($random(seed)) % 3;
      b = c * 3 + k - 1;
      setc(b, 1); cyc(6); watch();
      chk(ink_exp(k), {tog[2 - c], lv[2 - c] | tog[2 - c]});
      chk(k > 1, !error_n);
      chk(k == 1, print_enable);
      setc(b, 0); cyc(6);
    end
    setc(BAB, 1); setc(CLO, 1); cyc(6); watch();
    chk(3'b011, {tog[2], lv[2], tog[1]});
    setc(PKT, 1); cyc(6); chk(0, error_n);
    pulse(EC); cyc(6); chk(2'b11, {error_n, print_enable});
    setc(CAB, 1); cyc(6); chk(1, error_n);
    setc(PKT, 0); cyc(6); chk(2'b01, {error_n, busy});
    setc(BAB, 0); setc(CLO, 0); setc(CAB, 0); cyc(6); chk(1, error_n);
    setc(BLO, 1); setc(COUT, 1); cyc(6); watch();
    chk(3'b101, {tog[2], tog[1], lv[1]});
    setc(BLO, 0); setc(COUT, 0); cyc(6); watch();
    chk(2'b01, {tog[1], lv[1]});
    pulse(LF); cyc(6); watch();
    chk(2'b01, {tog[0], lv[0]});
    chk(3'b010, {error_n, busy, rx_enable});
    k = sent; cyc(5); chk(k, sent);
    pulse(PC); cyc(6); chk(2'b11, {error_n, print_enable});
    setc(PKT, 1); pulse(LF); cyc(6);
    chk(2'b11, {error_n, print_enable});
    pulse(PC); setc(PKT, 0);
    setc(BOUT, 1); cyc(6); pulse(EF); cyc(6); watch();
    chk(3'b100, {tog[0], lv[2] | tog[2], lv[1] | tog[1]});
    chk(0, error_n);
    setc(BOUT, 0); pulse(PC); cyc(6);
    k = 10 + $unsigned($random(seed)) % 80;
    wp <= k[7:0]; pulse(WA); wp <= 8'(99 - k); pulse(WA); cyc(6);
    chk(1, error_n);
    wp <= 8'h01; pulse(WA); cyc(6); watch();
    chk(5'h1f, {tog, eq});
    chk(0, error_n);
    pulse(WC); cyc(6);
    for (b = EXM; b <= DP; b++) begin
      setc(b, 1); cyc(6); watch(); chk(1, tog[3]);
      setc(b, 0);
    end
    cyc(6); watch(); chk(2'b01, {tog[3], lv[3]});
    for (k = 0; k < 6; k++) begin
      snap = cnt;
      setc(PRQ, k == 3); setc(PSEL, k != 4);
      case (k)
        0: i_psei_host_model.cmd(0);
        1, 3: pulse(PR);
        5: i_psei_host_model.cmd(1);
        default: i_psei_host_model.cmd(2);
      endcase
      idle();
      for (b = 0; b < 6; b++) g[b] = (cnt[b] - snap[b] == 1);
      chk(init_exp(k), g);
    end
    setc(PSEL, 1); setc(PRQ, 0);
    for (b = MF; b <= CMF; b++) begin
      setc(b, 1); cyc(6); watch();
      chk(6'h27, {tog, lv[2:1]});
      chk(0, error_n);
      setc(b, 0); cyc(1); reset <= 1'b1; cyc(6); reset <= 1'b0; idle();
    end
    tally_and_finish();
  end
endmodule : tb
